/* File: logic/gpio_sf_pkg.sv */
package gpio_sf_pkg;
  localparam int NUM_LINES = 17;
  localparam int NUM_AIN = 6;
  localparam int AIN_FIRST = 9;
  localparam int AIN_W = 16;
  localparam int LINE_JOIN = 0;
  localparam int LINE_CTS = 1;
  localparam int LINE_RTS = 2;
  localparam int LINE_DTR = 3;
  localparam int LINE_DSR = 4;
  localparam int LINE_PWR = 15;
  localparam int LINE_NET = 16;
  localparam int SYNC_W = NUM_LINES + 1;

  localparam logic [2:0] MODE_UNMON = 3'h0;
  localparam logic [2:0] MODE_MON = 3'h1;
  localparam logic [2:0] MODE_OUT_LO = 3'h2;
  localparam logic [2:0] MODE_OUT_HI = 3'h3;
  localparam logic [2:0] MODE_ANALOG = 3'h4;
  localparam logic [2:0] MODE_ALT = 3'h5;

  localparam logic [7:0] ADDR_MODE_LO = 8'h00;
  localparam logic [7:0] ADDR_MODE_HI = 8'h04;
  localparam logic [7:0] ADDR_DOUT = 8'h08;
  localparam logic [7:0] ADDR_DIN = 8'h0C;
  localparam logic [7:0] ADDR_AMASK = 8'h10;
  localparam logic [7:0] ADDR_AIN0 = 8'h20;
  localparam logic [7:0] ADDR_AIN_END = 8'h38;
  localparam logic [7:0] ADDR_JOIN_TO = 8'h40;
  localparam logic [7:0] ADDR_PERIOD = 8'h44;
  localparam logic [7:0] ADDR_CFG = 8'h48;
  localparam logic [7:0] ADDR_CMD = 8'h4C;
  localparam logic [7:0] ADDR_FWD_LO = 8'h50;
  localparam logic [7:0] ADDR_FWD_HI = 8'h54;
  localparam logic [7:0] ADDR_FWD_OP = 8'h58;
  localparam logic [7:0] ADDR_STATUS = 8'h5C;
  localparam logic [7:0] ADDR_FWD_RESP = 8'h60;
  localparam logic [7:0] ADDR_DEST_LO = 8'h64;
  localparam logic [7:0] ADDR_DEST_HI = 8'h68;
  localparam int LO_LINES = 10;

  localparam int CMD_APPLY_BIT = 0;
  localparam int CMD_FWD_BIT = 1;
  localparam int CFG_TARGET_BIT = 0;
  localparam int CFG_DISPLAY_BIT = 1;
  localparam int CFG_LED_BIT = 2;
  localparam int CFG_SINK_LSB = 8;
  localparam logic [16:0] AIN_STAR = 17'h10000;

  localparam longint CLK_FREQ_HZ = 250000000;
  localparam longint FACTORY_HOLD_MS = 2000;
  localparam longint FACTORY_HOLD_CYC_DEF = FACTORY_HOLD_MS * CLK_FREQ_HZ / 1000;
  localparam longint SEC_S = 1;
  localparam longint SEC_CYC_DEF = SEC_S * CLK_FREQ_HZ;
  localparam longint BLINK_HALF_MS = 500;
  localparam longint BLINK_CYC_DEF = BLINK_HALF_MS * CLK_FREQ_HZ / 1000;
  localparam logic [2:0] STARTUP_CYC = 3'h4;

  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_BAR = 8'h7C;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [5:0] DISP_ADDR0 = 6'h02;
  localparam logic [5:0] DISP_BAR = 6'h12;
  localparam logic [5:0] DISP_LINE_ZERO = 6'h13;
  localparam logic [5:0] DISP_CR = 6'h24;

  typedef enum logic {FR_IDLE, FR_HELD} fr_state_t;
endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t q;
  sync_t d;

  // first stage feeds only the second stage
  always_comb begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= {RST_VAL, RST_VAL};
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_q = q.s2;
endmodule

/* File: logic/period_timer.sv */
`timescale 1ns/1ns
module period_timer #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_restart,
  input wire logic [W-1:0] i_period,
  output logic o_fire
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic fire;
  } tmr_t;
  tmr_t q;
  tmr_t d;

  // a period of zero parks the counter and never fires
  always_comb begin
    d = q;
    d.fire = 1'b0;
    if (i_restart || i_period == '0) begin
      d.cnt = '0;
    end else if (i_tick) begin
      if (W'(q.cnt + 1'b1) >= i_period) begin
        d.cnt = '0;
        d.fire = 1'b1;
      end else begin
        d.cnt = W'(q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_fire = q.fire;
endmodule

/* File: logic/gpio_special_function_sampler.sv */
`timescale 1ns/1ns
module gpio_special_function_sampler #(
  parameter int unsigned FACTORY_HOLD_CYC = 32'(gpio_sf_pkg::FACTORY_HOLD_CYC_DEF),
  parameter int unsigned SEC_CYC = 32'(gpio_sf_pkg::SEC_CYC_DEF),
  parameter int unsigned BLINK_CYC = 32'(gpio_sf_pkg::BLINK_CYC_DEF)
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [gpio_sf_pkg::NUM_LINES-1:0] i_gpio_in,
  output logic [gpio_sf_pkg::NUM_LINES-1:0] o_gpio_out,
  output logic [gpio_sf_pkg::NUM_LINES-1:0] o_gpio_oe,
  input wire logic i_factory_n,
  input wire logic i_sleeping,
  input wire logic i_end_device,
  input wire logic i_joined,
  input wire logic i_rts,
  input wire logic i_dtr,
  output logic o_cts,
  output logic o_dsr,
  output logic o_factory_restore,
  output logic o_bootloader,
  output logic o_wake,
  output logic o_permit_join,
  input wire logic [gpio_sf_pkg::NUM_AIN*gpio_sf_pkg::AIN_W-1:0] i_ain,
  output logic o_fwd_req,
  output logic [63:0] o_fwd_addr,
  output logic [31:0] o_fwd_op,
  input wire logic i_fwd_done,
  input wire logic [31:0] i_fwd_resp,
  output logic o_sample_req,
  output logic o_sample_to_sink,
  output logic [63:0] o_sample_dest,
  output logic [gpio_sf_pkg::NUM_LINES-1:0] o_sample_gpio,
  output logic o_advertise,
  input wire logic i_rx_valid,
  input wire logic [63:0] i_rx_addr,
  input wire logic [gpio_sf_pkg::NUM_LINES-1:0] i_rx_gpio,
  output logic o_disp_valid,
  output logic [7:0] o_disp_char,
  input wire logic i_disp_ready
);
  import gpio_sf_pkg::*;

  typedef struct packed {
    logic [NUM_LINES-1:0][2:0] mode;
    logic [NUM_LINES-1:0] dout;
    logic [7:0] join_to;
    logic [15:0] per_sh;
    logic [15:0] per_ap;
    logic tgt_sh;
    logic tgt_ap;
    logic disp_en;
    logic led_mgmt;
    logic [7:0] sink_sh;
    logic [7:0] sink_ap;
    logic [63:0] dest_sh;
    logic [63:0] dest_ap;
    logic [63:0] fwd_addr;
    logic [31:0] fwd_op;
    logic [31:0] fwd_resp;
    logic fwd_busy;
    logic fwd_req;
    logic [31:0] rdata;
    fr_state_t fr_st;
    logic [31:0] fr_cnt;
    logic restore;
    logic [2:0] st_cnt;
    logic started;
    logic boot;
    logic l0_prev;
    logic wake;
    logic [7:0] pj_cnt;
    logic permit;
    logic [31:0] sec_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [NUM_LINES-1:0] pin_out;
    logic [NUM_LINES-1:0] pin_oe;
    logic cts;
    logic dsr;
    logic sample_req;
    logic [NUM_LINES-1:0] sample_gpio;
    logic adv;
    logic disp_busy;
    logic disp_valid;
    logic [5:0] disp_idx;
    logic [7:0] disp_char;
    logic [63:0] disp_addr;
    logic [NUM_LINES-1:0] disp_gpio;
  } state_t;

  state_t q;
  state_t d;
  logic [SYNC_W-1:0] sync_w;
  logic pressed_w;
  logic tick_w;
  logic apply_w;
  logic sample_fire_w;
  logic adv_fire_w;
  logic [NUM_LINES-1:0] levels_w;
  logic [NUM_LINES-1:0] amask_w;
  logic [2:0] ain_ch_w;

  // pulled-up lines reset high so no false press or edge is seen
  pin_sync #(.W(SYNC_W), .RST_VAL({SYNC_W{1'b1}})) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_d({i_factory_n, i_gpio_in}),
    .o_q(sync_w)
  );

  period_timer #(.W(16)) u_sample_tmr (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_tick(tick_w),
    .i_restart(apply_w),
    .i_period(q.per_ap),
    .o_fire(sample_fire_w)
  );

  period_timer #(.W(8)) u_adv_tmr (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_tick(tick_w),
    .i_restart(apply_w),
    .i_period(q.sink_ap),
    .o_fire(adv_fire_w)
  );

  function automatic logic [7:0] disp_char_f(input logic [5:0] idx, input logic [63:0] addr,
                                             input logic [NUM_LINES-1:0] gpio);
    logic [63:0] sh;
    logic [3:0] nib;
    logic [5:0] k;
    sh = addr << {idx - DISP_ADDR0, 2'b00};
    nib = sh[63:60];
    k = idx - DISP_LINE_ZERO;
    if (idx < DISP_ADDR0) begin
      disp_char_f = CH_PLUS;
    end else if (idx < DISP_BAR) begin
      disp_char_f = (nib < 4'hA) ? CH_0 + {4'h0, nib} : CH_A + {4'h0, nib} - 8'h0A;
    end else if (idx == DISP_BAR) begin
      disp_char_f = CH_BAR;
    end else if (idx < DISP_CR) begin
      disp_char_f = gpio[k[4:0]] ? CH_1 : CH_0;
    end else begin
      disp_char_f = CH_CR;
    end
  endfunction

  assign pressed_w = ~sync_w[SYNC_W-1];
  assign tick_w = (q.sec_cnt == SEC_CYC - 1);
  assign apply_w = i_wr && (i_addr == ADDR_CMD) && i_wdata[CMD_APPLY_BIT];
  assign ain_ch_w = 3'((i_addr - ADDR_AIN0) >> 2);

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      amask_w[i] = (i >= AIN_FIRST) && (i < AIN_FIRST + NUM_AIN) && (q.mode[i] == MODE_ANALOG);
      levels_w[i] = sync_w[i] && !amask_w[i];
    end
  end

  always_comb begin
    d = q;
    d.restore = 1'b0;
    d.wake = 1'b0;
    d.fwd_req = 1'b0;
    d.adv = adv_fire_w;
    d.rdata = '0;
    d.sec_cnt = tick_w ? '0 : q.sec_cnt + 32'h1;
    if (q.blink_cnt == BLINK_CYC - 1) begin
      d.blink_cnt = '0;
      d.blink = ~q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + 32'h1;
    end
    if (i_fwd_done && q.fwd_busy) begin
      d.fwd_busy = 1'b0;
      d.fwd_resp = i_fwd_resp;
    end
    if (i_wr) begin
      case (i_addr)
        ADDR_MODE_LO: begin
          for (int i = 0; i < LO_LINES; i++) begin
            d.mode[i] = i_wdata[3*i +: 3];
          end
        end
        ADDR_MODE_HI: begin
          for (int i = LO_LINES; i < NUM_LINES; i++) begin
            d.mode[i] = i_wdata[3*(i-LO_LINES) +: 3];
          end
        end
        ADDR_DOUT: d.dout = i_wdata[NUM_LINES-1:0];
        ADDR_JOIN_TO: d.join_to = i_wdata[7:0];
        ADDR_PERIOD: d.per_sh = i_wdata[15:0];
        ADDR_CFG: begin
          d.tgt_sh = i_wdata[CFG_TARGET_BIT];
          d.disp_en = i_wdata[CFG_DISPLAY_BIT];
          d.led_mgmt = i_wdata[CFG_LED_BIT];
          d.sink_sh = i_wdata[CFG_SINK_LSB +: 8];
        end
        ADDR_DEST_LO: d.dest_sh[31:0] = i_wdata;
        ADDR_DEST_HI: d.dest_sh[63:32] = i_wdata;
        ADDR_FWD_LO: d.fwd_addr[31:0] = i_wdata;
        ADDR_FWD_HI: d.fwd_addr[63:32] = i_wdata;
        ADDR_FWD_OP: d.fwd_op = i_wdata;
        ADDR_CMD: begin
          // a forward asked for while one is in flight is dropped
          if (i_wdata[CMD_FWD_BIT] && !q.fwd_busy) begin
            d.fwd_busy = 1'b1;
            d.fwd_req = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // software sees shadow copies; the sampler runs from the applied set
    if (apply_w) begin
      d.per_ap = q.per_sh;
      d.tgt_ap = q.tgt_sh;
      d.sink_ap = q.sink_sh;
      d.dest_ap = q.dest_sh;
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      if (d.mode[i] != q.mode[i] && d.mode[i] == MODE_OUT_LO) begin
        d.dout[i] = 1'b0;
      end else if (d.mode[i] != q.mode[i] && d.mode[i] == MODE_OUT_HI) begin
        d.dout[i] = 1'b1;
      end
    end
    if (i_rd) begin
      case (i_addr)
        ADDR_MODE_LO: d.rdata = {2'h0, q.mode[LO_LINES-1:0]};
        ADDR_MODE_HI: d.rdata = {11'h0, q.mode[NUM_LINES-1:LO_LINES]};
        ADDR_DOUT: d.rdata = {15'h0, q.dout};
        ADDR_DIN: d.rdata = {15'h0, levels_w};
        ADDR_AMASK: d.rdata = {15'h0, amask_w};
        ADDR_JOIN_TO: d.rdata = {24'h0, q.join_to};
        ADDR_PERIOD: d.rdata = {16'h0, q.per_sh};
        ADDR_CFG: d.rdata = {16'h0, q.sink_sh, 5'h0, q.led_mgmt, q.disp_en, q.tgt_sh};
        ADDR_DEST_LO: d.rdata = q.dest_sh[31:0];
        ADDR_DEST_HI: d.rdata = q.dest_sh[63:32];
        ADDR_FWD_LO: d.rdata = q.fwd_addr[31:0];
        ADDR_FWD_HI: d.rdata = q.fwd_addr[63:32];
        ADDR_FWD_OP: d.rdata = q.fwd_op;
        ADDR_FWD_RESP: d.rdata = q.fwd_resp;
        ADDR_STATUS: d.rdata = {27'h0, q.disp_busy, q.fwd_busy, q.permit, q.boot, q.started};
        default: begin
          if (i_addr >= ADDR_AIN0 && i_addr < ADDR_AIN_END && i_addr[1:0] == 2'h0) begin
            d.rdata = (q.mode[AIN_FIRST + ain_ch_w] == MODE_ANALOG) ?
                      {16'h0, i_ain[AIN_W*ain_ch_w +: AIN_W]} : {15'h0, AIN_STAR};
          end
        end
      endcase
    end
    // startup window: sync chain fills before the button is judged
    if (!q.started) begin
      d.fr_st = FR_IDLE;
      if (q.st_cnt == STARTUP_CYC) begin
        d.started = 1'b1;
        d.boot = pressed_w;
      end else begin
        d.st_cnt = q.st_cnt + 3'h1;
      end
    end else begin
      case (q.fr_st)
        FR_IDLE: begin
          if (pressed_w && !i_sleeping) begin
            d.fr_st = FR_HELD;
            d.fr_cnt = '0;
          end
        end
        FR_HELD: begin
          if (i_sleeping) begin
            d.fr_st = FR_IDLE;
          end else if (pressed_w) begin
            if (q.fr_cnt != FACTORY_HOLD_CYC) begin
              d.fr_cnt = q.fr_cnt + 32'h1;
            end
          end else begin
            d.fr_st = FR_IDLE;
            d.restore = (q.fr_cnt == FACTORY_HOLD_CYC);
          end
        end
        default: d.fr_st = FR_IDLE;
      endcase
    end
    d.l0_prev = sync_w[LINE_JOIN];
    if (q.mode[LINE_JOIN] == MODE_ALT && q.l0_prev && !sync_w[LINE_JOIN]) begin
      if (i_end_device) begin
        d.wake = i_sleeping;
      end else if (q.join_to != 8'h0) begin
        d.permit = 1'b1;
        d.pj_cnt = q.join_to;
      end
    end else if (q.permit && tick_w) begin
      d.pj_cnt = q.pj_cnt - 8'h1;
      d.permit = (q.pj_cnt != 8'h1);
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      d.pin_oe[i] = (q.mode[i] == MODE_OUT_LO) || (q.mode[i] == MODE_OUT_HI);
      d.pin_out[i] = d.pin_oe[i] && q.dout[i];
    end
    d.cts = (q.mode[LINE_CTS] == MODE_ALT) && sync_w[LINE_CTS];
    d.dsr = (q.mode[LINE_DSR] == MODE_ALT) && sync_w[LINE_DSR];
    if (q.mode[LINE_RTS] == MODE_ALT) begin
      d.pin_oe[LINE_RTS] = 1'b1;
      d.pin_out[LINE_RTS] = i_rts;
    end
    if (q.mode[LINE_DTR] == MODE_ALT) begin
      d.pin_oe[LINE_DTR] = 1'b1;
      d.pin_out[LINE_DTR] = i_dtr;
    end
    if (q.mode[LINE_PWR] == MODE_ALT) begin
      d.pin_oe[LINE_PWR] = 1'b1;
      d.pin_out[LINE_PWR] = (i_end_device && q.led_mgmt) ? q.blink : 1'b1;
    end
    if (q.mode[LINE_NET] == MODE_ALT) begin
      d.pin_oe[LINE_NET] = 1'b1;
      d.pin_out[LINE_NET] = q.permit ? q.blink : i_joined;
    end
    d.sample_req = sample_fire_w;
    if (sample_fire_w) begin
      d.sample_gpio = levels_w;
    end
    // one sample on screen at a time; arrivals while busy are dropped
    if (!q.disp_busy) begin
      if (i_rx_valid && q.disp_en) begin
        d.disp_busy = 1'b1;
        d.disp_valid = 1'b1;
        d.disp_idx = '0;
        d.disp_addr = i_rx_addr;
        d.disp_gpio = i_rx_gpio;
        d.disp_char = CH_PLUS;
      end
    end else if (q.disp_valid && i_disp_ready) begin
      if (q.disp_idx == DISP_CR) begin
        d.disp_busy = 1'b0;
        d.disp_valid = 1'b0;
      end else begin
        d.disp_idx = q.disp_idx + 6'h1;
        d.disp_char = disp_char_f(q.disp_idx + 6'h1, q.disp_addr, q.disp_gpio);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_gpio_out = q.pin_out;
  assign o_gpio_oe = q.pin_oe;
  assign o_cts = q.cts;
  assign o_dsr = q.dsr;
  assign o_factory_restore = q.restore;
  assign o_bootloader = q.boot;
  assign o_wake = q.wake;
  assign o_permit_join = q.permit;
  assign o_fwd_req = q.fwd_req;
  assign o_fwd_addr = q.fwd_addr;
  assign o_fwd_op = q.fwd_op;
  assign o_sample_req = q.sample_req;
  assign o_sample_to_sink = q.tgt_ap;
  assign o_sample_dest = q.dest_ap;
  assign o_sample_gpio = q.sample_gpio;
  assign o_advertise = q.adv;
  assign o_disp_valid = q.disp_valid;
  assign o_disp_char = q.disp_char;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn || !i_ce);

  sequence long_hold_s;
    q.fr_st == FR_HELD && q.fr_cnt == FACTORY_HOLD_CYC;
  endsequence
  sequence release_s;
    !pressed_w && !i_sleeping;
  endsequence

  restore_after_hold_a: assert property (long_hold_s and release_s |=> o_factory_restore)
    else $error("restore pulse missing after long hold");
  restore_cause_a: assert property (o_factory_restore && $past(i_ce) |-> $past(q.fr_cnt) == FACTORY_HOLD_CYC)
    else $error("restore without full hold");
  sleep_ignore_a: assert property (i_sleeping && q.started |=> q.fr_st == FR_IDLE && !o_factory_restore)
    else $error("restore button seen while sleeping");
  boot_entry_a: assert property ($rose(o_bootloader) |-> $past(pressed_w) && !$past(q.started))
    else $error("bootloader entered without startup press");
  permit_open_a: assert property ($rose(o_permit_join) |-> $past(q.mode[LINE_JOIN]) == MODE_ALT && !$past(i_end_device))
    else $error("join permit opened wrongly");
  wake_cause_a: assert property (o_wake && $past(i_ce) |-> $past(i_end_device) && $past(i_sleeping))
    else $error("wake on non-sleeping node");
  rts_drive_a: assert property (q.mode[LINE_RTS] == MODE_ALT |=> o_gpio_oe[LINE_RTS] && o_gpio_out[LINE_RTS] == $past(i_rts))
    else $error("rts line not driven");
  cts_follow_a: assert property (q.mode[LINE_CTS] != MODE_ALT |=> !o_cts)
    else $error("cts active outside mode 5");
  net_led_a: assert property (q.mode[LINE_NET] == MODE_ALT && !q.permit && i_joined |=> o_gpio_out[LINE_NET])
    else $error("network indicator low while joined");
  sample_off_a: assert property (q.per_ap == 16'h0 && !apply_w |=> ##1 !o_sample_req)
    else $error("sample sent with period zero");
  disp_begin_a: assert property ($rose(q.disp_busy) |-> o_disp_valid && o_disp_char == CH_PLUS)
    else $error("display does not open with plus");
endmodule

/* File: test/fwd_partner.sv */
`timescale 1ns/1ns
module fwd_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_slow,
  input wire logic [31:0] i_op,
  output logic o_done,
  output logic [31:0] o_resp
);
  initial begin
    o_done = 1'b0;
    o_resp = 32'h0;
    forever begin
      @(posedge i_clk);
      if (i_req) begin
        repeat (i_slow ? 12 : 1) @(posedge i_clk);
        o_done <= 1'b1;
        o_resp <= i_op ^ 32'h5A5A_0000;
        @(posedge i_clk);
        o_done <= 1'b0;
        // stale answer inverted so a late capture cannot pass
        o_resp <= ~o_resp;
      end
    end
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import gpio_sf_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_factory_n = 0, i_sleeping = 0;
  logic i_end_device = 0, i_joined = 0, i_rts = 0, i_dtr = 0, i_rx_valid = 0;
  logic i_disp_ready = 0, i_slow = 0, i_fwd_done, o_cts, o_dsr, o_factory_restore;
  logic o_bootloader, o_wake, o_permit_join, o_fwd_req, o_sample_req, o_sample_to_sink;
  logic o_advertise, o_disp_valid, ce = 1;
  logic [7:0] i_addr = 0, o_disp_char;
  logic [31:0] i_wdata = 0, o_rdata, o_fwd_op, i_fwd_resp, rd, op;
  logic [63:0] o_fwd_addr, o_sample_dest, i_rx_addr = 0, a64;
  logic [16:0] i_gpio_in = 17'h1, i_rx_gpio = 0, o_gpio_out, o_gpio_oe, o_sample_gpio, g;
  logic [95:0] i_ain = 0;
  logic [7:0] got[$], exp[$];
  int n_errors = 0, tests_run = 0, seed = 31986, ns = 0, na = 0, nf = 0, nw = 0;
  gpio_special_function_sampler #(.FACTORY_HOLD_CYC(20), .SEC_CYC(10), .BLINK_CYC(4)) dut (
    .i_clk, .i_resetn, .i_ce(ce), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_gpio_in,
    .o_gpio_out, .o_gpio_oe, .i_factory_n, .i_sleeping, .i_end_device, .i_joined, .i_rts,
    .i_dtr, .o_cts, .o_dsr, .o_factory_restore, .o_bootloader, .o_wake, .o_permit_join,
    .i_ain, .o_fwd_req, .o_fwd_addr, .o_fwd_op, .i_fwd_done, .i_fwd_resp, .o_sample_req,
    .o_sample_to_sink, .o_sample_dest, .o_sample_gpio, .o_advertise, .i_rx_valid,
    .i_rx_addr, .i_rx_gpio, .o_disp_valid, .o_disp_char, .i_disp_ready);
  fwd_partner far_end (.i_clk, .i_req(o_fwd_req), .i_slow, .i_op(o_fwd_op),
    .o_done(i_fwd_done), .o_resp(i_fwd_resp));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  // random stalls on the character sink
  always @(posedge i_clk) begin
    i_disp_ready <= 1'($random(seed));
    if (o_sample_req) ns++;
    if (o_advertise) na++;
    if (o_factory_restore) nf++;
    if (o_wake) nw++;
    if (o_disp_valid && i_disp_ready) got.push_back(o_disp_char);
  end
  task automatic chk(string nm, logic [95:0] seen, logic [95:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdr(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic press(int n);
    i_factory_n <= 1'b0;
    wait_n(n);
    i_factory_n <= 1'b1;
    wait_n(8);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #80000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    wait_n(8);
    chk("boot", o_bootloader, 1);
    i_factory_n <= 1'b1;
    rd = 0;
    for (int i = 0; i < 10; i++) rd[3*i +: 3] = (i < 5) ? MODE_ALT : MODE_OUT_LO;
    wr(ADDR_MODE_LO, rd);
    wr(ADDR_MODE_HI, {11'h0, MODE_ALT, MODE_ALT, 9'h0, MODE_ANALOG, MODE_OUT_LO});
    g = 17'($random(seed)) | 17'h1;
    op = $random(seed);
    i_gpio_in <= g;
    {i_dtr, i_rts} <= op[1:0];
    i_joined <= 1'b1;
    i_ain <= {$random(seed), $random(seed), $random(seed)};
    wr(ADDR_DOUT, op);
    wait_n(4);
    chk("outs", {o_gpio_out[16:15], o_gpio_out[10:5], o_gpio_oe[10:5]},
      {2'b11, op[10:5], 6'h3F});
    chk("flow", {o_gpio_out[3:2], o_cts, o_dsr}, {op[1:0], g[1], g[4]});
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    wr(ADDR_DOUT, ~op);
    ce <= 1'b1;
    rdr(ADDR_DOUT);
    chk("freeze", rd, {15'h0, op[16:0]});
    rdr(ADDR_DIN);
    chk("din", rd, g & ~17'h00800);
    rdr(ADDR_AMASK);
    chk("amask", rd, 32'h0000_0800);
    for (int c = 0; c < NUM_AIN; c++) begin
      rdr(ADDR_AIN0 + 8'(4*c));
      chk("ain", rd, (c == 2) ? {16'h0, i_ain[16*c +: 16]} : 32'h0001_0000);
    end
    wr(ADDR_JOIN_TO, 2);
    i_gpio_in[0] <= 1'b0;
    wait_n(6);
    chk("permit", o_permit_join, 1);
    wait_n(30);
    chk("permit end", o_permit_join, 0);
    {i_gpio_in[0], i_end_device, i_sleeping} <= 3'b111;
    wait_n(4);
    i_gpio_in[0] <= 1'b0;
    wait_n(6);
    chk("wake", {nw, o_permit_join}, {32'd1, 1'b0});
    press(30);
    i_sleeping <= 1'b0;
    press(30);
    press(15);
    press(15);
    chk("restore", nf, 1);
    for (int k = 0; k < 2; k++) begin
      a64 = {$random(seed), $random(seed)};
      op = $random(seed);
      i_slow <= k[0];
      wr(ADDR_FWD_LO, a64[31:0]);
      wr(ADDR_FWD_HI, a64[63:32]);
      wr(ADDR_FWD_OP, op);
      wr(ADDR_CMD, 32'h2);
      rd = 32'h8;
      for (int t = 0; t < 40 && rd[3]; t++) rdr(ADDR_STATUS);
      rdr(ADDR_FWD_RESP);
      chk("fwd", {o_fwd_addr, rd}, {a64, op ^ 32'h5A5A_0000});
    end
    a64 = {$random(seed), $random(seed)};
    wr(ADDR_DEST_LO, a64[31:0]);
    wr(ADDR_DEST_HI, a64[63:32]);
    wr(ADDR_PERIOD, 1);
    wr(ADDR_CFG, 32'h0100);
    wait_n(12);
    chk("not applied", {ns, o_sample_dest}, 96'h0);
    wr(ADDR_CMD, 1);
    wait_n(1);
    {ns, na} = 0;
    wait_n(45);
    chk("periodic", ns >= 3 && ns <= 5 && na >= 3 && na <= 5, 1);
    chk("sample lines", o_sample_gpio, {g[16:1], 1'b0} & ~17'h00800);
    chk("dest", {o_sample_to_sink, o_sample_dest}, {1'b0, a64});
    wr(ADDR_PERIOD, 0);
    wr(ADDR_CFG, 32'h3);
    wr(ADDR_CMD, 1);
    wait_n(1);
    ns = 0;
    wait_n(30);
    chk("off", {ns, o_sample_to_sink}, {32'd0, 1'b1});
    a64 = {$random(seed), $random(seed)};
    g = 17'($random(seed));
    exp = '{CH_PLUS, CH_PLUS};
    for (int n = 15; n >= 0; n--) begin
      exp.push_back((a64[4*n +: 4] < 10 ? 8'h30 : 8'h37) + 8'(a64[4*n +: 4]));
    end
    exp.push_back(CH_BAR);
    for (int n = 0; n < NUM_LINES; n++) exp.push_back(g[n] ? CH_1 : CH_0);
    exp.push_back(CH_CR);
    got.delete();
    // second arrival lands mid-stream and must be dropped
    for (int p = 0; p < 2; p++) begin
      {i_rx_addr, i_rx_gpio, i_rx_valid} <= {a64, g, 1'b1};
      wait_n(1);
      i_rx_valid <= 1'b0;
      wait_n(5);
    end
    for (int t = 0; t < 400 && got.size() < 37; t++) wait_n(1);
    wait_n(20);
    chk("disp len", got.size(), 37);
    foreach (exp[n]) chk("disp char", got[n], exp[n]);
    close_out;
  end
endmodule
